// File: pkg/fpu_pkg.sv
/*
 * Constants and types for the floating multiply/divide/compare unit.
 * Assumes a 16-bit CPU word, 48-bit floating values held as three words.
 */
package fpu_pkg;

  // Floating format: sign, excess-64 binary exponent, 40-bit fraction
  localparam int WORD_W = 16;
  localparam int FP_W = 48;
  localparam int NUM_WORDS = 3;
  localparam int SIGN_BIT = 47;
  localparam int EXP_HI = 46;
  localparam int EXP_LO = 40;
  localparam int MANT_W = 40;
  localparam logic signed [9:0] EXP_BIAS = 10'sh040;
  localparam logic signed [9:0] EXP_TOP = 10'sh07f;
  localparam logic [46:0] MAX_MAG = 47'h7fff_ffff_ffff;
  localparam logic [FP_W-1:0] TRUE_ZERO = 48'h0000_0000_0000;

  // Memory word holding the base of the memory floating accumulator
  localparam logic [WORD_W-1:0] MFA_PTR_ADDR = 16'h0001;

  // APB register byte offsets
  localparam logic [7:0] STATUS_OFS = 8'h00;
  localparam logic [7:0] MASK_OFS = 8'h04;
  localparam logic [7:0] FLAGS_OFS = 8'h08;

  // Event bits of status and mask
  localparam int EV_W = 3;
  localparam int EV_OVF = 0;
  localparam int EV_DIVZ = 1;
  localparam int EV_DONE = 2;
  localparam logic [EV_W-1:0] MASK_RESET = 3'h0;

  typedef enum logic [1:0] {OP_MUL, OP_DIV, OP_CMP} op_t;

  typedef enum logic [2:0] {
    S_IDLE, S_FETCH, S_EXEC, S_SAVE_PTR, S_SAVE, S_LOAD_PTR, S_LOAD
  } fsm_t;

endpackage

// File: src/fpu_mant_engine.sv
/*
 * Iterative mantissa engine: shift-add multiply or restoring divide.
 * Assumes start is a one-cycle pulse while idle and a < 2*b for divide.
 */
`timescale 1ns/1ps
`default_nettype none

module fpu_mant_engine #(
  parameter int MW = 40
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic is_div,
  input wire logic [MW-1:0] a,
  input wire logic [MW-1:0] b,
  output logic done_q,
  output logic [2*MW-1:0] res_q
);

  localparam int CW = $clog2(MW + 2);

  typedef struct packed {
    logic busy;
    logic div;
    logic [CW-1:0] cnt;
    logic [2*MW-1:0] p;
    logic [MW:0] rem;
    logic [MW-1:0] b;
    logic done;
  } eng_t;

  eng_t s_q;
  eng_t s_d;

  always_comb begin
    logic [MW:0] sum;
    logic [MW:0] r2;
    logic ge;
    s_d = s_q;
    sum = '0;
    r2 = '0;
    ge = 1'b0;
    s_d.done = 1'b0;
    if (start && !s_q.busy) begin
      s_d.busy = 1'b1;
      s_d.div = is_div;
      s_d.cnt = '0;
      s_d.b = b;
      s_d.rem = {1'b0, a};
      s_d.p = is_div ? '0 : {{MW{1'b0}}, a};
    end else if (s_q.busy) begin
      if (s_q.div) begin
        ge = s_q.rem >= {1'b0, s_q.b};
        r2 = ge ? s_q.rem - {1'b0, s_q.b} : s_q.rem;
        s_d.rem = {r2[MW-1:0], 1'b0};
        s_d.p = {s_q.p[2*MW-2:0], ge};
      end else begin
        sum = {1'b0, s_q.p[2*MW-1:MW]} + (s_q.p[0] ? {1'b0, s_q.b} : '0);
        s_d.p = {sum, s_q.p[MW-1:1]};
      end
      s_d.cnt = s_q.cnt + 1'b1;
      // Divide needs one more step for the integer quotient bit
      if (s_q.cnt == CW'(s_q.div ? MW : MW - 1)) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign done_q = s_q.done;
  assign res_q = s_q.p;

endmodule

`default_nettype wire

// File: src/float_mul_div_compare.sv
/*
 * Floating multiply, divide and compare unit with its scratch accumulator,
 * automatic save/reload of the accumulator and an APB status port.
 * Assumes the decoder holds op_valid until op_done_q or op_nonfloat_q,
 * and memory answers a held mem_req_q with a one-cycle mem_ack.
 */
`timescale 1ns/1ps
`default_nettype none

module float_mul_div_compare (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic float_mode_flag,
  input wire logic op_valid,
  input wire fpu_pkg::op_t op_code,
  input wire logic [fpu_pkg::WORD_W-1:0] op_ea,
  output logic op_busy_q,
  output logic op_done_q,
  output logic op_nonfloat_q,
  output logic ovf_q,
  output logic carry_q,
  output logic gr7_we_q,
  output logic [fpu_pkg::WORD_W-1:0] gr7_data_q,
  output logic mem_req_q,
  output logic mem_we_q,
  output logic [fpu_pkg::WORD_W-1:0] mem_addr_q,
  output logic [fpu_pkg::WORD_W-1:0] mem_wdata_q,
  input wire logic mem_ack,
  input wire logic [fpu_pkg::WORD_W-1:0] mem_rdata,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_q,
  output logic pready_q,
  output logic pslverr_q,
  output logic irq_q
);
  import fpu_pkg::*;

  typedef struct packed {
    fsm_t st;
    op_t opc;
    logic [1:0] cnt;
    logic [WORD_W-1:0] ea;
    logic [WORD_W-1:0] base;
    logic [FP_W-1:0] scratch_float_acc;  // Three words, no bus path to it
    logic [FP_W-1:0] opnd;
    logic fm_prev;
    logic save_pend;
    logic load_pend;
    logic eng_start;
    logic busy;
    logic done;
    logic nonfloat;
    logic ovf;
    logic carry;
    logic gr7_we;
    logic [WORD_W-1:0] gr7_data;
    logic mem_req;
    logic mem_we;
    logic [WORD_W-1:0] mem_addr;
    logic [WORD_W-1:0] mem_wdata;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } unit_t;

  unit_t s_q;
  unit_t s_d;
  logic eng_done;
  logic [2*MANT_W-1:0] eng_res;

  // Word 0 is the most significant word of a floating value
  function automatic logic [WORD_W-1:0] word_get(logic [FP_W-1:0] v, logic [1:0] i);
    case (i)
      2'h0: word_get = v[47:32];
      2'h1: word_get = v[31:16];
      default: word_get = v[15:0];
    endcase
  endfunction

  function automatic logic [FP_W-1:0] word_put(logic [FP_W-1:0] v, logic [1:0] i,
                                               logic [WORD_W-1:0] w);
    logic [FP_W-1:0] r;
    r = v;
    case (i)
      2'h0: r[47:32] = w;
      2'h1: r[31:16] = w;
      default: r[15:0] = w;
    endcase
    word_put = r;
  endfunction

  fpu_mant_engine #(
    .MW(MANT_W)
  ) u_engine (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .start(s_q.eng_start),
    .is_div(s_q.opc == OP_DIV),
    .a(s_q.scratch_float_acc[MANT_W-1:0]),
    .b(s_q.opnd[MANT_W-1:0]),
    .done_q(eng_done),
    .res_q(eng_res)
  );

  always_comb begin
    logic fm_fall;
    logic fm_rise;
    logic [EV_W-1:0] evt;
    logic signed [9:0] ex;
    logic [MANT_W-1:0] mant;
    logic sr;
    logic za;
    logic zb;
    logic apb_done;
    logic a_gt;
    s_d = s_q;
    fm_fall = s_q.fm_prev && !float_mode_flag;
    fm_rise = !s_q.fm_prev && float_mode_flag;
    evt = '0;
    ex = '0;
    mant = '0;
    sr = s_q.scratch_float_acc[SIGN_BIT] ^ s_q.opnd[SIGN_BIT];
    za = s_q.scratch_float_acc == TRUE_ZERO;
    zb = s_q.opnd == TRUE_ZERO;
    a_gt = 1'b0;
    apb_done = psel && penable && s_q.pready;
    s_d.fm_prev = float_mode_flag;
    s_d.save_pend = s_q.save_pend | fm_fall;
    s_d.load_pend = s_q.load_pend | fm_rise;
    s_d.eng_start = 1'b0;
    s_d.done = 1'b0;
    s_d.nonfloat = 1'b0;
    s_d.gr7_we = 1'b0;

    case (s_q.st)
      S_IDLE: begin
        if (s_q.save_pend) begin
          s_d.save_pend = fm_fall;
          s_d.st = S_SAVE_PTR;
        end else if (s_q.load_pend) begin
          s_d.load_pend = fm_rise;
          s_d.st = S_LOAD_PTR;
        end else if (op_valid && !s_q.done && !s_q.nonfloat) begin
          if (float_mode_flag) begin
            s_d.opc = op_code;
            s_d.ea = op_ea;
            s_d.cnt = '0;
            s_d.st = S_FETCH;
          end else begin
            s_d.nonfloat = 1'b1;
          end
        end
      end
      S_FETCH, S_LOAD: begin
        // Three words: the operand before any arithmetic, or the accumulator on reload
        if (!s_q.mem_req) begin
          s_d.mem_req = 1'b1;
          s_d.mem_we = 1'b0;
          s_d.mem_addr = (s_q.st == S_FETCH ? s_q.ea : s_q.base) + 16'(s_q.cnt);
        end else if (mem_ack) begin
          s_d.mem_req = 1'b0;
          s_d.cnt = s_q.cnt + 2'h1;
          if (s_q.st == S_FETCH) begin
            s_d.opnd = word_put(s_q.opnd, s_q.cnt, mem_rdata);
          end else begin
            s_d.scratch_float_acc = word_put(s_q.scratch_float_acc, s_q.cnt, mem_rdata);
          end
          if (s_q.cnt == 2'(NUM_WORDS - 1)) begin
            s_d.st = s_q.st == S_FETCH ? S_EXEC : S_IDLE;
            s_d.eng_start = s_q.st == S_FETCH && s_q.opc != OP_CMP;
          end
        end
      end
      S_SAVE_PTR, S_LOAD_PTR: begin
        if (!s_q.mem_req) begin
          s_d.mem_req = 1'b1;
          s_d.mem_we = 1'b0;
          s_d.mem_addr = MFA_PTR_ADDR;
        end else if (mem_ack) begin
          s_d.mem_req = 1'b0;
          s_d.base = mem_rdata;
          s_d.cnt = '0;
          s_d.st = s_q.st == S_SAVE_PTR ? S_SAVE : S_LOAD;
        end
      end
      S_SAVE: begin
        if (!s_q.mem_req) begin
          s_d.mem_req = 1'b1;
          s_d.mem_we = 1'b1;
          s_d.mem_addr = s_q.base + 16'(s_q.cnt);
          s_d.mem_wdata = word_get(s_q.scratch_float_acc, s_q.cnt);
        end else if (mem_ack) begin
          s_d.mem_req = 1'b0;
          s_d.mem_we = 1'b0;
          s_d.cnt = s_q.cnt + 2'h1;
          if (s_q.cnt == 2'(NUM_WORDS - 1)) begin
            s_d.st = S_IDLE;
          end
        end
      end
      S_EXEC: begin
        if (s_q.opc == OP_CMP) begin
          // Sign-magnitude order; true zero carries a clear sign
          if (s_q.scratch_float_acc[SIGN_BIT] != s_q.opnd[SIGN_BIT]) begin
            a_gt = !s_q.scratch_float_acc[SIGN_BIT];
          end else if (s_q.scratch_float_acc[SIGN_BIT]) begin
            a_gt = s_q.scratch_float_acc[46:0] < s_q.opnd[46:0];
          end else begin
            a_gt = s_q.scratch_float_acc[46:0] > s_q.opnd[46:0];
          end
          s_d.ovf = a_gt || s_q.scratch_float_acc == s_q.opnd;
          s_d.carry = s_q.scratch_float_acc == s_q.opnd;
          s_d.done = 1'b1;
          s_d.st = S_IDLE;
        end else if (eng_done) begin  // Carry untouched here
          if (s_q.opc == OP_MUL) begin
            ex = $signed({3'h0, s_q.scratch_float_acc[EXP_HI:EXP_LO]})
                 + $signed({3'h0, s_q.opnd[EXP_HI:EXP_LO]}) - EXP_BIAS;
            // Extra low product bit fills a one-place shift
            if (eng_res[2*MANT_W-1]) begin
              mant = eng_res[2*MANT_W-1:MANT_W];
            end else begin
              mant = eng_res[2*MANT_W-2:MANT_W-1];
              ex = ex - 10'sh001;
            end
          end else begin
            ex = $signed({3'h0, s_q.scratch_float_acc[EXP_HI:EXP_LO]})
                 - $signed({3'h0, s_q.opnd[EXP_HI:EXP_LO]}) + EXP_BIAS;
            if (eng_res[MANT_W]) begin
              mant = eng_res[MANT_W:1];
              ex = ex + 10'sh001;
            end else begin
              mant = eng_res[MANT_W-1:0];
            end
          end
          s_d.ovf = 1'b0;
          if (s_q.opc == OP_DIV && zb) begin
            s_d.scratch_float_acc = {sr, MAX_MAG};
            s_d.ovf = 1'b1;
            evt[EV_DIVZ] = 1'b1;
          end else if (za || zb) begin
            s_d.scratch_float_acc = TRUE_ZERO;
          end else if (ex < 10'sh000) begin
            s_d.scratch_float_acc = TRUE_ZERO;
            s_d.ovf = 1'b1;
          end else if (ex > EXP_TOP) begin
            s_d.scratch_float_acc = {sr, MAX_MAG};
            s_d.ovf = 1'b1;
          end else begin
            s_d.scratch_float_acc = {sr, ex[6:0], mant};
          end
          s_d.gr7_we = 1'b1;
          s_d.gr7_data = s_d.scratch_float_acc[47:32];
          s_d.done = 1'b1;
          s_d.st = S_IDLE;
        end
      end
      default: s_d.st = S_IDLE;
    endcase

    s_d.busy = s_d.st != S_IDLE;
    evt[EV_OVF] = s_d.done && s_d.ovf && s_q.opc != OP_CMP;
    evt[EV_DONE] = s_d.done;

    // APB slave, one wait state; registers are status, mask and flags only
    s_d.pready = psel && penable && !s_q.pready;
    s_d.pslverr = 1'b0;
    s_d.prdata = '0;
    if (psel && penable && !s_q.pready) begin
      if (paddr == STATUS_OFS) begin
        s_d.prdata = 32'(s_q.status);
      end else if (paddr == MASK_OFS) begin
        s_d.prdata = 32'(s_q.mask);
      end else if (paddr == FLAGS_OFS) begin
        s_d.prdata = {28'h0, s_q.busy, float_mode_flag, s_q.carry, s_q.ovf};
      end else begin
        s_d.pslverr = 1'b1;
      end
    end
    // Read clears only the bits it returned, so later events are never lost
    if (apb_done && !pwrite && paddr == STATUS_OFS) begin
      s_d.status = (s_q.status & ~s_q.prdata[EV_W-1:0]) | evt;
    end else begin
      s_d.status = s_q.status | evt;
    end
    if (apb_done && pwrite && paddr == MASK_OFS) begin
      s_d.mask = pwdata[EV_W-1:0];
    end
    s_d.irq = |(s_d.status & s_d.mask);
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign op_busy_q = s_q.busy;
  assign op_done_q = s_q.done;
  assign op_nonfloat_q = s_q.nonfloat;
  assign ovf_q = s_q.ovf;
  assign carry_q = s_q.carry;
  assign gr7_we_q = s_q.gr7_we;
  assign gr7_data_q = s_q.gr7_data;
  assign mem_req_q = s_q.mem_req;
  assign mem_we_q = s_q.mem_we;
  assign mem_addr_q = s_q.mem_addr;
  assign mem_wdata_q = s_q.mem_wdata;
  assign prdata_q = s_q.prdata;
  assign pready_q = s_q.pready;
  assign pslverr_q = s_q.pslverr;
  assign irq_q = s_q.irq;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  nonfloat_refuse_a: assert property (
    s_q.st == S_IDLE && op_valid && !float_mode_flag && !s_q.save_pend && !s_q.load_pend
    && !s_q.done && !s_q.nonfloat |=> op_nonfloat_q && !op_busy_q)
    else $error("non-floating op not refused");
  fetch_address_a: assert property (
    s_q.st == S_FETCH && mem_req_q |-> !mem_we_q && mem_addr_q == s_q.ea + 16'(s_q.cnt))
    else $error("operand fetch address wrong");
  gr7_copy_a: assert property (
    gr7_we_q |-> gr7_data_q == s_q.scratch_float_acc[47:32] && op_done_q && s_q.opc != OP_CMP)
    else $error("register 7 copy mismatch");
  result_norm_a: assert property (
    op_done_q && s_q.opc != OP_CMP |-> s_q.scratch_float_acc == TRUE_ZERO || s_q.scratch_float_acc[MANT_W-1])
    else $error("result neither normalized nor zero");
  ovf_max_a: assert property (
    op_done_q && s_q.opc != OP_CMP && ovf_q && s_q.scratch_float_acc != TRUE_ZERO
    |-> s_q.scratch_float_acc[46:0] == MAX_MAG)
    else $error("overflow result not largest value");
  divzero_flag_a: assert property (
    s_q.st == S_EXEC && s_q.opc == OP_DIV && eng_done && s_q.opnd == TRUE_ZERO
    |=> ovf_q ##0 s_q.status[EV_DIVZ])
    else $error("divide by zero not flagged");
  carry_keep_a: assert property (
    op_done_q && s_q.opc != OP_CMP |-> carry_q == $past(carry_q))
    else $error("multiply or divide changed carry");
  cmp_codes_a: assert property (
    op_done_q && s_q.opc == OP_CMP
    |-> !(carry_q && !ovf_q) && !gr7_we_q && $stable(s_q.scratch_float_acc))
    else $error("compare result or side effect wrong");
  save_pointer_a: assert property (
    s_q.st == S_SAVE_PTR && mem_req_q |-> mem_addr_q == MFA_PTR_ADDR && !mem_we_q)
    else $error("save pointer read wrong");
  load_start_a: assert property (
    s_q.st == S_IDLE && s_q.load_pend && !s_q.save_pend |=> s_q.st == S_LOAD_PTR)
    else $error("reload not started");
  irq_level_a: assert property (
    op_done_q && s_q.mask[EV_DONE] |-> irq_q && s_q.status[EV_DONE])
    else $error("interrupt not raised");

endmodule

`default_nettype wire

// File: sim/fpu_mem_model.sv
/*
 * Main memory partner for the floating unit: a word array that answers
 * each held request with a one-cycle acknowledge, promptly or slowly.
 * Assumes the unit holds mem_req_q and its address until mem_ack.
 */
`timescale 1ns/1ps
`default_nettype none

module fpu_mem_model (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic slow,
  input wire logic mem_req_q,
  input wire logic mem_we_q,
  input wire logic [15:0] mem_addr_q,
  input wire logic [15:0] mem_wdata_q,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  logic [15:0] mem [0:65535];
  logic [15:0] rd_log [$];
  int wait_n;

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_ack <= 1'b0;
      mem_rdata <= 16'h5a5a;
      wait_n <= 0;
    end else if (mem_ack) begin
      mem_ack <= 1'b0;
      // Data released: flip it so a late sample never looks valid
      mem_rdata <= ~mem_rdata;
    end else if (mem_req_q && wait_n >= (slow ? 3 : 0)) begin
      mem_ack <= 1'b1;
      wait_n <= 0;
      if (mem_we_q) begin
        mem[mem_addr_q] <= mem_wdata_q;
      end else begin
        mem_rdata <= mem[mem_addr_q];
        rd_log.push_back(mem_addr_q);
      end
    end else begin
      wait_n <= mem_req_q ? wait_n + 1 : 0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

`default_nettype wire

// File: sim/test_float_mul_div_compare.sv
/*
 * Self-checking bench for the floating multiply/divide/compare unit.
 * Assumes the memory partner model and the APB status port of the unit.
 */
`timescale 1ns/1ps
`default_nettype none

module test_float_mul_div_compare;
  import fpu_pkg::*;
  logic core_clk = 1'b0, rst_b = 1'b0, float_mode_flag = 1'b0, op_valid = 1'b0;
  logic mem_slow = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  op_t op_code = OP_MUL;
  logic [15:0] op_ea = 16'h0000;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic op_busy_q, op_done_q, op_nonfloat_q, ovf_q, carry_q, gr7_we_q, mem_req_q;
  logic mem_we_q, mem_ack, pready_q, pslverr_q, irq_q;
  logic [15:0] gr7_data_q, mem_addr_q, mem_wdata_q, mem_rdata;
  logic [31:0] prdata_q, rd;
  int error_cnt = 0, cmp_count = 0;
  logic [47:0] sfa_exp;
  logic got_done, got_nf, got_gw;
  logic [1:0] got_oc;
  logic [15:0] got_gd;
  localparam logic [15:0] BASE = 16'h0100;
  localparam logic [39:0] HALF = 40'h80_0000_0000;

  float_mul_div_compare u_float_mul_div_compare (.core_clk, .rst_b, .float_mode_flag,
    .op_valid, .op_code, .op_ea, .op_busy_q, .op_done_q, .op_nonfloat_q, .ovf_q,
    .carry_q, .gr7_we_q, .gr7_data_q, .mem_req_q, .mem_we_q, .mem_addr_q, .mem_wdata_q,
    .mem_ack, .mem_rdata, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_q,
    .pready_q, .pslverr_q, .irq_q);
  fpu_mem_model u_fpu_mem_model (.core_clk, .rst_b, .slow(mem_slow), .mem_req_q,
    .mem_we_q, .mem_addr_q, .mem_wdata_q, .mem_ack, .mem_rdata);

  always #5 core_clk = ~core_clk;

  function automatic logic [47:0] fp(logic s, logic [6:0] e, logic [39:0] m);
    return {s, e, m};
  endfunction

  // Result with overflow flag on top; exponent range is 0..127
  function automatic logic [48:0] fin(logic s, int e, logic [39:0] m);
    if (e < 0) return {1'b1, TRUE_ZERO};
    if (e > 127) return {1'b1, s, MAX_MAG};
    return {1'b0, s, e[6:0], m};
  endfunction

  function automatic logic [48:0] mul_ref(logic [47:0] a, logic [47:0] b);
    logic [79:0] p;
    int e;
    if (!a[39] || !b[39]) return 49'h0;
    p = a[39:0] * b[39:0];
    e = int'(a[46:40]) + int'(b[46:40]) - 64;
    if (!p[79]) begin
      p = p << 1;
      e--;
    end
    return fin(a[47] ^ b[47], e, p[79:40]);
  endfunction

  function automatic logic [48:0] div_ref(logic [47:0] a, logic [47:0] b);
    logic [80:0] q;
    int e;
    if (!b[39]) return {1'b1, a[47] ^ b[47], MAX_MAG};
    if (!a[39]) return 49'h0;
    q = {a[39:0], 40'h0} / b[39:0];
    e = int'(a[46:40]) - int'(b[46:40]) + 64;
    if (q[40]) begin
      q = q >> 1;
      e++;
    end
    return fin(a[47] ^ b[47], e, q[39:0]);
  endfunction

  function automatic logic signed [48:0] key(logic [47:0] a);
    return a[47] ? -$signed({2'b00, a[46:0]}) : $signed({2'b00, a[46:0]});
  endfunction

  task automatic check(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Outputs read here still hold their values from before this edge
    do @(posedge core_clk); while (pready_q !== 1'b1 && ++n < 50);
    check("apb ready", pready_q, 1'b1);
    rd = pslverr_q ? 32'hdead_0000 : prdata_q;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic run_op(input op_t op, input logic [15:0] ea, input logic [47:0] v);
    int n = 0;
    // Operands are always normalized or true zero
    u_fpu_mem_model.mem[ea] = v[47:32];
    u_fpu_mem_model.mem[ea + 16'h1] = v[31:16];
    u_fpu_mem_model.mem[ea + 16'h2] = v[15:0];
    u_fpu_mem_model.rd_log.delete();
    got_gw = 1'b0;
    @(posedge core_clk);
    op_valid <= 1'b1;
    op_code <= op;
    op_ea <= ea;
    do begin
      @(negedge core_clk);
      if (gr7_we_q === 1'b1) begin
        got_gw = 1'b1;
        got_gd = gr7_data_q;
      end
    end while (op_done_q !== 1'b1 && op_nonfloat_q !== 1'b1 && ++n < 400);
    got_done = op_done_q;
    got_nf = op_nonfloat_q;
    got_oc = {ovf_q, carry_q};
    @(posedge core_clk);
    op_valid <= 1'b0;
  endtask

  task automatic arith(input op_t op, input logic [15:0] ea, input logic [47:0] v);
    logic [48:0] r;
    logic c;
    r = (op == OP_MUL) ? mul_ref(sfa_exp, v) : div_ref(sfa_exp, v);
    c = carry_q;
    run_op(op, ea, v);
    check("done", {got_done, got_nf}, 2'b10);
    check("gr7", {got_gw, got_gd}, {1'b1, r[47:32]});
    check("ovf", got_oc[1], r[48]);
    check("carry", got_oc[0], c);
    check("fetch n", u_fpu_mem_model.rd_log.size(), 3);
    check("fetch", {u_fpu_mem_model.rd_log[0], u_fpu_mem_model.rd_log[1],
      u_fpu_mem_model.rd_log[2]}, {ea, ea + 16'h1, ea + 16'h2});
    sfa_exp = r[47:0];
  endtask

  task automatic fcmp(input logic [15:0] ea, input logic [47:0] v);
    logic signed [48:0] ka, kb;
    ka = key(sfa_exp);
    kb = key(v);
    run_op(OP_CMP, ea, v);
    check("cmp no gr7", {got_done, got_gw}, 2'b10);
    check("cmp oc", got_oc, ka < kb ? 2'b00 : (ka > kb ? 2'b10 : 2'b11));
  endtask

  task automatic set_mode(input logic m);
    int n = 0;
    u_fpu_mem_model.rd_log.delete();
    @(posedge core_clk);
    float_mode_flag <= m;
    repeat (3) @(negedge core_clk);
    while (op_busy_q !== 1'b0 && ++n < 400) @(negedge core_clk);
    check("mode busy", op_busy_q, 1'b0);
    check("ptr read", u_fpu_mem_model.rd_log[0], MFA_PTR_ADDR);
  endtask

  task automatic t_save();
    set_mode(1'b0);
    check("saved", {u_fpu_mem_model.mem[BASE],
      u_fpu_mem_model.mem[BASE + 16'h1], u_fpu_mem_model.mem[BASE + 16'h2]}, sfa_exp);
  endtask

  task automatic t_reload(input logic [47:0] v);
    u_fpu_mem_model.mem[16'h0001] = BASE;
    {u_fpu_mem_model.mem[BASE], u_fpu_mem_model.mem[BASE + 16'h1]} = v[47:16];
    u_fpu_mem_model.mem[BASE + 16'h2] = v[15:0];
    sfa_exp = v;
    set_mode(1'b1);
    check("reload", {u_fpu_mem_model.rd_log[1],
      u_fpu_mem_model.rd_log[2], u_fpu_mem_model.rd_log[3]}, {BASE, BASE + 16'h1, BASE + 16'h2});
  endtask

  task automatic t_irq(input logic lvl, input logic [2:0] st);
    repeat (2) @(negedge core_clk);
    check("irq", irq_q, lvl);
    apb(1'b0, STATUS_OFS, 32'h0);
    check("status", rd[2:0], st);
    repeat (2) @(negedge core_clk);
    check("irq clear", irq_q, 1'b0);
  endtask

  initial begin
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    apb(1'b1, FLAGS_OFS, 32'h0000_000f);
    apb(1'b0, FLAGS_OFS, 32'h0);
    check("flags rst", rd[3:0], 4'h0);
    apb(1'b0, MASK_OFS, 32'h0);
    check("mask rst", rd[2:0], MASK_RESET);
    apb(1'b0, 8'h0c, 32'h0);
    check("unmapped", rd, 32'hdead_0000);
    for (int i = 0; i < 3; i++) begin
      run_op(op_t'(i), 16'h0300, fp(1'b0, 7'h41, HALF));
      check("nonfloat", {got_done, got_nf, got_gw}, 3'b010);
      check("no fetch", u_fpu_mem_model.rd_log.size(), 0);
    end
    t_reload(fp(1'b0, 7'h41, 40'h80_0000_0001));
    apb(1'b1, MASK_OFS, 32'h0000_0007);
    apb(1'b0, STATUS_OFS, 32'h0);
    arith(OP_MUL, 16'h0200, fp(1'b1, 7'h41, HALF));
    t_irq(1'b1, 3'b100);
    mem_slow <= 1'b1;
    arith(OP_DIV, 16'h0210, fp(1'b0, 7'h41, HALF));
    fcmp(16'h0220, fp(1'b0, 7'h01, HALF));
    fcmp(16'h0230, fp(1'b1, 7'h7f, HALF));
    fcmp(16'h0240, fp(1'b1, 7'h41, 40'h80_0000_0001));
    t_save();
    t_reload(sfa_exp);
    mem_slow <= 1'b0;
    arith(OP_MUL, 16'h0250, fp(1'b0, 7'h7f, HALF));
    apb(1'b0, STATUS_OFS, 32'h0);
    arith(OP_MUL, 16'h0260, fp(1'b0, 7'h7f, HALF));
    t_irq(1'b1, 3'b101);
    apb(1'b0, FLAGS_OFS, 32'h0);
    check("flags", rd[3:0], 4'h7);
    apb(1'b1, MASK_OFS, 32'h0000_0002);
    arith(OP_MUL, 16'h0270, fp(1'b0, 7'h40, HALF));
    repeat (2) @(negedge core_clk);
    check("irq masked", irq_q, 1'b0);
    arith(OP_DIV, 16'h0280, TRUE_ZERO);
    t_irq(1'b1, 3'b111);
    arith(OP_MUL, 16'h0290, fp(1'b0, 7'h01, HALF));
    arith(OP_MUL, 16'h02a0, fp(1'b0, 7'h01, HALF));
    fcmp(16'h02b0, fp(1'b1, 7'h41, HALF));
    t_save();
    summarize();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #300000;
    error_cnt++;
    summarize();
  end
endmodule

`default_nettype wire
